// ==== adc_front_model.sv ====
// Purpose: analog inputs and sample capacitor beside the control
// Assumes: levels are codes, ff at high_reference, 00 at low_reference
// Notes:   unpowered comparator toggles, so no stale answer helps
`timescale 1ns/1ps
module adc_front_model (
    // clock
    input  wire logic         aclk,
    // from the control
    input  wire logic [3:0]   channel_select,
    input  wire logic         converter_power,
    input  wire logic         sample_connect,
    input  wire logic [7:0]   dac_trial,
    // analog inputs, one byte per channel
    input  wire logic [127:0] analog_levels,
    // to the control
    output logic              comparator_above
);
    logic [7:0] held_charge;
    logic       noise = 1'h0;
    // capacitor follows the chosen pin only while connected
    always @(posedge aclk) begin
        noise <= ~noise;
        if (sample_connect)
            held_charge <= analog_levels[channel_select*8 +: 8];
    end
    // codes saturate at the references
    assign comparator_above = converter_power ?
        (held_charge >= dac_trial) : noise;
endmodule // adc_front_model

// ==== adc_seq_cfg.svh ====
// Purpose: constants for the converter sequencing control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses of aligned words
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define OFS_RESULT        4'h0
`define OFS_CTRL          4'h4
`define OFS_IRQ_STATUS    4'h8
`define OFS_IRQ_MASK      4'hc

// ------------------------------------------------------------
// control/status fields and reset values
// ------------------------------------------------------------
`define BIT_DONE          7
`define BIT_ON            5
`define CTRL_RESET        8'h00
`define RESULT_RESET      8'h00
`define CTRL_WR_MASK      8'h2f

// ------------------------------------------------------------
// timing, in converter clock periods; halt settle count in aclk cycles
// ------------------------------------------------------------
`define CONV_PERIODS      4'hc
`define SAMPLE_PERIODS    4'h4
`define SAR_STEPS         4'h8
`define HALT_SETTLE_CYC   8'h40

`endif

// ==== adc_seq_checker.sv ====
// Purpose: port-level checks of the converter sequencing control
// Assumes: one clock, synchronous active-low reset
// Notes:   phase lengths are not judged across a control write or halt
`timescale 1ns/1ps
module adc_seq_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // front end
    input wire logic        converter_power,
    input wire logic        sample_connect,
    input wire logic [7:0]  dac_trial,
    input wire logic        halt_mode
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_power_on: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
        s_axi_awaddr == 4'h4 && s_axi_wdata[5] && !halt_mode
        |-> ##[1:3] converter_power) else $error("on write left power off");
    a_settle_gap: assert property (
        $rose(converter_power) |-> (!sample_connect) [*8])
        else $error("sampling began during settle");
    // a write restarts the phases, so lengths pause around one
    a_sample_len: assert property (
        disable iff (!aresetn || s_axi_wvalid || halt_mode)
        $rose(sample_connect) |-> sample_connect [*8] ##1 !sample_connect)
        else $error("sampling phase not four periods");
    a_sar_len: assert property (
        disable iff (!aresetn || s_axi_wvalid || halt_mode)
        $fell(sample_connect) && converter_power
        |-> (!sample_connect) [*8] ##1 (!sample_connect) [*8]
            ##1 sample_connect)
        else $error("approximation phase not eight periods");
    a_cut_off: assert property (
        sample_connect |-> converter_power) else $error("sampling unpowered");
    a_trial_idle: assert property (
        !converter_power || sample_connect |-> dac_trial == 8'h00)
        else $error("trial value outside conversion");
    a_halt_off: assert property (
        halt_mode [*3] |-> !converter_power) else $error("powered in halt");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule // adc_seq_checker

bind adc_seq_ctrl adc_seq_checker adc_seq_checker_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .converter_power(converter_power),
    .sample_connect(sample_connect), .dac_trial(dac_trial),
    .halt_mode(halt_mode));

// ==== adc_seq_ctrl.sv ====
// Purpose: sequencing control of an 8-bit successive-approximation ADC
// Assumes: comparator answer is synchronous to aclk
// Notes:   converter clock is aclk divided by two
//
// Notes on behaviour
// - a conversion takes 12 converter clock periods, each two aclk
// - sampling phase then 8 approximation steps with input cut off
// - while on, sampling and conversion repeat back to back
// - setting the on bit powers up and starts converting the channel
// - at end of conversion set done flag, load result, no interrupt; code sets irq_status_r bit 0, irq if enabled in irq_mask_r
// - control write with on bit set aborts, clears flag, restarts
// - done flag bit 7 set by hardware, cleared by result read or write
// - clearing on bit 5 powers down and stops conversions
// - channel field bits 3:0 selects analog input 0 to 15
// - full-scale input gives ff, input at low reference gives 00
// - result is 8 bits, read only, resets to 00
// - wait mode has no effect; halt disables, settle after wakeup
// - control/status resets to 00: off, flag clear, input 0
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // analog front end
    output logic [3:0]       channel_select,
    output logic             converter_power,
    output logic             sample_connect,
    output logic [7:0]       dac_trial,
    input  wire logic        comparator_above,
    // low power modes
    input  wire logic        halt_mode,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    seq_state_e  state_r;
    logic        div_r;
    logic [3:0]  period_r;
    logic [7:0]  settle_r;
    logic [7:0]  sar_r;
    logic [7:0]  result_r;
    logic        on_r;
    logic        done_r;
    logic [3:0]  chan_r;
    logic [1:0]  irq_status_r;
    logic [1:0]  irq_mask_r;

    // bus holding registers
    logic        aw_held_r;
    logic        w_held_r;
    logic [3:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [1:0]  bresp_r;

    logic        wr_fire;
    logic        rd_fire;
    logic        ctrl_wr;
    logic        result_rd;
    logic        tick;
    logic        conv_end;
    logic        ctrl_wr_on;
    logic [7:0]  trial_bit;
    logic [7:0]  ctrl_view;

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    // address and data are taken independently, in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign rd_fire = s_axi_arvalid && !rvalid_r;
    assign ctrl_wr = wr_fire && (awaddr_r == `OFS_CTRL) && wstrb_r[0];
    assign result_rd = rd_fire && (s_axi_araddr == `OFS_RESULT);
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // capture write address and data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 4'h0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (awaddr_r == `OFS_RESULT || awaddr_r == `OFS_CTRL ||
                         awaddr_r == `OFS_IRQ_STATUS ||
                         awaddr_r == `OFS_IRQ_MASK) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // control/status as software sees it, reserved bits read zero
    assign ctrl_view = {done_r, 1'b0, on_r, 1'b0, chan_r};

    // read data path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= 2'b00;
            unique case (s_axi_araddr)
                `OFS_RESULT:     rdata_r <= {24'h000000, result_r};
                `OFS_CTRL:       rdata_r <= {24'h000000, ctrl_view};
                `OFS_IRQ_STATUS: rdata_r <= {30'h0, irq_status_r};
                `OFS_IRQ_MASK:   rdata_r <= {30'h0, irq_mask_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control/status register
    // ------------------------------------------------------------
    // reserved bits are masked off, so a stray one cannot stick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_r   <= 1'(`CTRL_RESET >> `BIT_ON);
            chan_r <= 4'(`CTRL_RESET);
        end else if (ctrl_wr) begin
            on_r   <= wdata_r[`BIT_ON];
            chan_r <= 4'(wdata_r[3:0] & `CTRL_WR_MASK);
        end
    end

    // done flag: completion beats a result-read clear in the same cycle; a control write wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_r <= 1'b0;
        end else if (conv_end) begin
            done_r <= 1'b1;
        end else if (ctrl_wr || result_rd) begin
            done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // converter sequencer
    // ------------------------------------------------------------
    // converter clock enable at half the aclk rate; phase cleared while
    // settling and on restart, else the first period could be one aclk
    always_ff @(posedge aclk) begin
        if (!aresetn || state_r == ST_OFF || state_r == ST_SETTLE ||
            ctrl_wr_on) begin
            div_r <= 1'b0;
        end else begin
            div_r <= !div_r;
        end
    end

    assign tick = div_r;
    assign ctrl_wr_on = ctrl_wr && wdata_r[`BIT_ON];
    assign conv_end = tick && state_r == ST_CONV &&
                      period_r == `CONV_PERIODS - 4'h1 && !ctrl_wr;
    assign trial_bit = 8'h80 >> (period_r - `SAMPLE_PERIODS);

    // state, period count and approximation register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r  <= ST_OFF;
            period_r <= 4'h0;
            settle_r <= 8'h00;
            sar_r    <= 8'h00;
        end else if (halt_mode || (ctrl_wr && !wdata_r[`BIT_ON])) begin
            state_r  <= ST_OFF;
            period_r <= 4'h0;
        end else if (ctrl_wr_on) begin
            // abort, and restart from sampling, or from settling if off
            state_r  <= (state_r == ST_OFF) ? ST_SETTLE : ST_SAMPLE;
            period_r <= 4'h0;
            settle_r <= `HALT_SETTLE_CYC;
            sar_r    <= 8'h00;
        end else begin
            unique case (state_r)
                ST_OFF: begin
                    // resume after halt if still switched on
                    if (on_r) begin
                        state_r  <= ST_SETTLE;
                        settle_r <= `HALT_SETTLE_CYC;
                    end
                end
                ST_SETTLE: begin
                    if (settle_r == 8'h00) begin
                        state_r  <= ST_SAMPLE;
                        period_r <= 4'h0;
                    end else begin
                        settle_r <= settle_r - 8'h01;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        period_r <= period_r + 4'h1;
                        if (period_r == `SAMPLE_PERIODS - 4'h1) begin
                            state_r <= ST_CONV;
                            sar_r   <= 8'h00;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        // keep trial bit if input is above the trial
                        if (comparator_above) begin
                            sar_r <= sar_r | trial_bit;
                        end
                        if (period_r == `CONV_PERIODS - 4'h1) begin
                            state_r  <= ST_SAMPLE;
                            period_r <= 4'h0;
                        end else begin
                            period_r <= period_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // result register, held until next conversion ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_r <= `RESULT_RESET;
        end else if (conv_end) begin
            result_r <= comparator_above ? (sar_r | trial_bit) : sar_r;
        end
    end

    // analog front end drive
    assign channel_select  = chan_r;
    assign converter_power = state_r != ST_OFF;
    assign sample_connect  = state_r == ST_SAMPLE;
    assign dac_trial = (state_r == ST_CONV) ? (sar_r | trial_bit) : 8'h00;

    // ------------------------------------------------------------
    // interrupt: bit 0 conversion done, bit 1 halt shutdown
    // ------------------------------------------------------------
    // the converter itself raises no interrupt; this is a wrapper event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= 2'b00;
            irq_mask_r   <= 2'b00;
        end else begin
            irq_status_r <= irq_status_r
                & ~((wr_fire && awaddr_r == `OFS_IRQ_STATUS && wstrb_r[0])
                    ? wdata_r[1:0] : 2'b00)
                | {halt_mode && state_r != ST_OFF, conv_end};
            if (wr_fire && awaddr_r == `OFS_IRQ_MASK && wstrb_r[0]) begin
                irq_mask_r <= wdata_r[1:0];
            end
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

endmodule // adc_seq_ctrl

// ==== adc_seq_ctrl_test.sv ====
// Purpose: self-checking bench of the converter sequencing control
// Assumes: one clock of 50 ns, reset held ten cycles
// Notes:   table rows first, then awkward cases, reset last
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_seq_ctrl_test;
    typedef struct packed {
        logic [3:0] chan;
        logic [7:0] level;
        logic [7:0] code;
    } row_s;
    row_s rows [4] = '{'{4'h0, 8'h00, 8'h00}, '{4'h5, 8'h5a, 8'h5a},
                       '{4'ha, 8'h80, 8'h80}, '{4'hf, 8'hff, 8'hff}};
    logic         aclk = 1'h0, aresetn = 1'h0, halt_mode = 1'h0;
    logic [3:0]   s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]   s_axi_wstrb = 4'hf, channel_select;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic         s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic         converter_power, sample_connect, comparator_above;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rr, br;
    logic [7:0]   dac_trial;
    logic [127:0] analog_levels = 128'h0;
    int           errors = 0, checks_done = 0;

    adc_seq_ctrl adc_seq_ctrl_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .channel_select(channel_select),
        .converter_power(converter_power),
        .sample_connect(sample_connect), .dac_trial(dac_trial),
        .comparator_above(comparator_above), .halt_mode(halt_mode),
        .irq(irq));
    adc_front_model adc_front_model_i (
        .aclk(aclk), .channel_select(channel_select),
        .converter_power(converter_power), .sample_connect(sample_connect),
        .dac_trial(dac_trial), .analog_levels(analog_levels),
        .comparator_above(comparator_above));

    // ------------------------------------------------------------
    // clock, bus tasks and checks
    // ------------------------------------------------------------
    always #25 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        #1;
        while (s_axi_awvalid || s_axi_wvalid) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            #1;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        br = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    // rready raised late so the slave must hold its answer
    task automatic axr(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // poll the flag under a bound, optionally take the result
    task automatic wait_done(input bit take);
        rd = 32'h0;
        for (int n = 0; n < 200 && rd[7] !== 1'h1; n++)
            axr(`OFS_CTRL, rd, rr);
        chk("done", rd[7], 1'h1);
        if (take)
            axr(`OFS_RESULT, rd, rr);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog, far beyond the several hundred cycles expected
    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        report_and_stop;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[i]) begin
            analog_levels[rows[i].chan*8 +: 8] <= rows[i].level;
            axw(`OFS_CTRL, 32'h20 | rows[i].chan);
            wait_done(1);
            chk("result", rd, 32'(rows[i].code));
            chk("chan", 32'(channel_select), 32'(rows[i].chan));
            axr(`OFS_CTRL, rd, rr);
            chk("ctrl", rd, 32'h20 | rows[i].chan);
            $display("row %0d done", i);
        end
        axw(`OFS_CTRL, 32'h0f);
        analog_levels[127:120] <= 8'h3c;
        repeat (60) @(posedge aclk);
        chk("power", 32'(converter_power), 32'h0);
        axr(`OFS_RESULT, rd, rr);
        chk("held", rd, 32'hff);
        axw(`OFS_CTRL, 32'h2f);
        wait_done(1);
        chk("first", rd, 32'h3c);
        analog_levels[127:120] <= 8'h11;
        repeat (2) wait_done(1);
        chk("rerun", rd, 32'h11);
        $display("off and continuous done");
        wait_done(0);
        axw(`OFS_CTRL, 32'h2f);
        axr(`OFS_CTRL, rd, rr);
        chk("abort", rd, 32'h2f);
        axw(`OFS_IRQ_MASK, 32'h1);
        wait_done(1);
        chk("irq", 32'(irq), 32'h1);
        axw(`OFS_IRQ_STATUS, 32'h3);
        chk("irq_clr", 32'(irq), 32'h0);
        axw(`OFS_IRQ_MASK, 32'h0);
        wait_done(1);
        chk("irq_mask", 32'(irq), 32'h0);
        halt_mode <= 1'h1;
        repeat (4) @(posedge aclk);
        chk("halt", 32'(converter_power), 32'h0);
        axr(`OFS_IRQ_STATUS, rd, rr);
        chk("halt_st", rd[1], 1'h1);
        halt_mode <= 1'h0;
        wait_done(1);
        chk("resume", rd, 32'h11);
        axw(`OFS_RESULT, 32'h55);
        chk("bresp_ok", 32'(br), 32'h0);
        axr(`OFS_RESULT, rd, rr);
        chk("read_only", rd, 32'h11);
        axw(4'h2, 32'h0);
        chk("bresp_err", 32'(br), 32'h2);
        axr(4'h2, rd, rr);
        chk("unmapped", {rd[29:0], rr}, 32'h2);
        for (int c = 0; c < 16; c++) begin
            axw(`OFS_CTRL, 32'(c));
            chk("sel", 32'(channel_select), 32'(c));
        end
        $display("abort irq halt select done");
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        axr(`OFS_RESULT, rd, rr);
        chk("rst_res", rd, 32'h0);
        axr(`OFS_CTRL, rd, rr);
        chk("rst_ctrl", rd, 32'h0);
        $display("reset done");
        report_and_stop;
    end
endmodule // adc_seq_ctrl_test

// ==== adc_seq_pkg.sv ====
// Purpose: types for the converter sequencing control block
// Assumes: constants live in adc_seq_cfg.svh
// Notes:   one-hot sequencer states
package adc_seq_pkg;
    typedef enum logic [3:0] {
        ST_OFF    = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_CONV   = 4'b1000
    } seq_state_e;
endpackage
